/* File: rtl/dbg_pkg.sv */
// shared constants and carrier types for the debug event and test port
package dbg_pkg;
	// ---------------------------------------------------------------
	// timing counts
	// ---------------------------------------------------------------
	localparam int ACK_CYCLES = 3;
	localparam logic [1:0] ACK_CNT_RESET = 2'h0;

	// ---------------------------------------------------------------
	// tap instruction register layout
	// ---------------------------------------------------------------
	localparam int IR_WIDTH = 4;
	localparam logic [3:0] IR_CAPTURE_VALUE = 4'h1;
	localparam logic [3:0] IR_RESET_VALUE = 4'hF;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR,
		TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
		TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
		TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} dbg_tap_state_t;

	// one test port as seen after pin routing
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} dbg_jtag_in_t;

	// two-signal view of an open-drain or tristate pin
	typedef struct packed {
		logic out;
		logic oe;
	} dbg_pin_drv_t;
endpackage

/* File: rtl/dbg_tap.sv */
// ieee 1149.1 test access port running on the test clock
`timescale 1ns/10ps
module dbg_tap (
	input wire logic tck_in, // test clock, link domain
	input wire logic trst_n_in, // routed test reset, active low
	input wire logic tms_in, // routed mode select
	input wire logic tdi_in, // routed serial data in
	output logic tdo_out, // serial data out
	output logic tdo_oe_out, // high while tdo is driven
	output dbg_pkg::dbg_tap_state_t state_out // controller state
);
	dbg_pkg::dbg_tap_state_t state_ff;
	dbg_pkg::dbg_tap_state_t nxt_state;
	logic [dbg_pkg::IR_WIDTH-1:0] ir_shift_ff;
	logic [dbg_pkg::IR_WIDTH-1:0] ir_ff;
	logic bypass_ff;
	logic tdo_ff;
	logic tdo_oe_ff;

	// ---------------------------------------------------------------
	// state sequencing
	// ---------------------------------------------------------------
	// next state from tms, standard sixteen-state walk
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			dbg_pkg::TAP_RESET: nxt_state = tms_in ? dbg_pkg::TAP_RESET : dbg_pkg::TAP_IDLE;
			dbg_pkg::TAP_IDLE: nxt_state = tms_in ? dbg_pkg::TAP_SEL_DR : dbg_pkg::TAP_IDLE;
			dbg_pkg::TAP_SEL_DR: nxt_state = tms_in ? dbg_pkg::TAP_SEL_IR : dbg_pkg::TAP_CAP_DR;
			dbg_pkg::TAP_CAP_DR: nxt_state = tms_in ? dbg_pkg::TAP_EXIT1_DR : dbg_pkg::TAP_SHIFT_DR;
			dbg_pkg::TAP_SHIFT_DR: nxt_state = tms_in ? dbg_pkg::TAP_EXIT1_DR : dbg_pkg::TAP_SHIFT_DR;
			dbg_pkg::TAP_EXIT1_DR: nxt_state = tms_in ? dbg_pkg::TAP_UPD_DR : dbg_pkg::TAP_PAUSE_DR;
			dbg_pkg::TAP_PAUSE_DR: nxt_state = tms_in ? dbg_pkg::TAP_EXIT2_DR : dbg_pkg::TAP_PAUSE_DR;
			dbg_pkg::TAP_EXIT2_DR: nxt_state = tms_in ? dbg_pkg::TAP_UPD_DR : dbg_pkg::TAP_SHIFT_DR;
			dbg_pkg::TAP_UPD_DR: nxt_state = tms_in ? dbg_pkg::TAP_SEL_DR : dbg_pkg::TAP_IDLE;
			dbg_pkg::TAP_SEL_IR: nxt_state = tms_in ? dbg_pkg::TAP_RESET : dbg_pkg::TAP_CAP_IR;
			dbg_pkg::TAP_CAP_IR: nxt_state = tms_in ? dbg_pkg::TAP_EXIT1_IR : dbg_pkg::TAP_SHIFT_IR;
			dbg_pkg::TAP_SHIFT_IR: nxt_state = tms_in ? dbg_pkg::TAP_EXIT1_IR : dbg_pkg::TAP_SHIFT_IR;
			dbg_pkg::TAP_EXIT1_IR: nxt_state = tms_in ? dbg_pkg::TAP_UPD_IR : dbg_pkg::TAP_PAUSE_IR;
			dbg_pkg::TAP_PAUSE_IR: nxt_state = tms_in ? dbg_pkg::TAP_EXIT2_IR : dbg_pkg::TAP_PAUSE_IR;
			dbg_pkg::TAP_EXIT2_IR: nxt_state = tms_in ? dbg_pkg::TAP_UPD_IR : dbg_pkg::TAP_SHIFT_IR;
			dbg_pkg::TAP_UPD_IR: nxt_state = tms_in ? dbg_pkg::TAP_SEL_DR : dbg_pkg::TAP_IDLE;
		endcase
	end

	// tms sampled on rising tck; trst resets without any clock
	always_ff @(posedge tck_in or negedge trst_n_in) begin
		if (!trst_n_in) begin
			state_ff <= dbg_pkg::TAP_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ---------------------------------------------------------------
	// instruction and bypass shifting
	// ---------------------------------------------------------------
	// tdi sampled on rising tck into whichever path is selected
	always_ff @(posedge tck_in or negedge trst_n_in) begin
		if (!trst_n_in) begin
			ir_shift_ff <= '0;
			ir_ff <= dbg_pkg::IR_RESET_VALUE;
			bypass_ff <= 1'b0;
		end else begin
			if (state_ff == dbg_pkg::TAP_CAP_IR) begin
				ir_shift_ff <= dbg_pkg::IR_CAPTURE_VALUE;
			end else if (state_ff == dbg_pkg::TAP_SHIFT_IR) begin
				ir_shift_ff <= {tdi_in, ir_shift_ff[dbg_pkg::IR_WIDTH-1:1]};
			end
			if (state_ff == dbg_pkg::TAP_UPD_IR) begin
				ir_ff <= ir_shift_ff;
			end else if (state_ff == dbg_pkg::TAP_RESET) begin
				ir_ff <= dbg_pkg::IR_RESET_VALUE;
			end
			if (state_ff == dbg_pkg::TAP_CAP_DR) begin
				bypass_ff <= 1'b0;
			end else if (state_ff == dbg_pkg::TAP_SHIFT_DR) begin
				bypass_ff <= tdi_in;
			end
		end
	end

	// ---------------------------------------------------------------
	// output on the falling edge
	// ---------------------------------------------------------------
	// falling-edge update gives the tester half a tck of setup
	always_ff @(negedge tck_in or negedge trst_n_in) begin
		if (!trst_n_in) begin
			tdo_ff <= 1'b0;
			tdo_oe_ff <= 1'b0;
		end else begin
			tdo_ff <= (state_ff == dbg_pkg::TAP_SHIFT_IR) ? ir_shift_ff[0] : bypass_ff;
			tdo_oe_ff <= (state_ff == dbg_pkg::TAP_SHIFT_IR) ||
				(state_ff == dbg_pkg::TAP_SHIFT_DR);
		end
	end

	assign tdo_out = tdo_ff;
	assign tdo_oe_out = tdo_oe_ff;
	assign state_out = state_ff;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_tdo_only_in_shift;
		@(posedge tck_in) disable iff (!trst_n_in)
		tdo_oe_ff |-> (state_ff == dbg_pkg::TAP_SHIFT_IR ||
			state_ff == dbg_pkg::TAP_SHIFT_DR);
	endproperty
	a_tdo_only_in_shift: assert property (p_tdo_only_in_shift)
		else $error("tdo driven outside a shift state");

	property p_five_tms_reset;
		@(posedge tck_in) disable iff (!trst_n_in)
		tms_in [*5] |=> state_ff == dbg_pkg::TAP_RESET;
	endproperty
	a_five_tms_reset: assert property (p_five_tms_reset)
		else $error("five tms highs did not reach reset");

	property p_idle_holds;
		@(posedge tck_in) disable iff (!trst_n_in)
		(state_ff == dbg_pkg::TAP_IDLE && !tms_in) |=> state_ff == dbg_pkg::TAP_IDLE;
	endproperty
	a_idle_holds: assert property (p_idle_holds)
		else $error("idle left while tms low");

	property p_tdo_stable_rise;
		@(posedge tck_in) disable iff (!trst_n_in)
		(state_ff == dbg_pkg::TAP_SHIFT_DR) |=> tdo_ff == bypass_ff;
	endproperty
	a_tdo_stable_rise: assert property (p_tdo_stable_rise)
		else $error("tdo did not present bypass bit at falling edge");
endmodule // dbg_tap

/* File: rtl/dbg_port.sv */
// debug event lines, pin routing and test access port wrapper
`timescale 1ns/10ps
module dbg_port (
	input wire logic clk_in, // core clock, 20 mhz
	input wire logic reset_n_in, // async system reset, active low
	input wire logic pin_route_select_in, // high selects alternate pins
	input wire logic mcu_debug_event_in, // dedicated mcu event pin level
	output logic mcu_debug_event_out, // dedicated mcu pin drive value
	output logic mcu_debug_event_oe_out, // dedicated mcu pin enable
	input wire logic dsp_debug_event_in, // dedicated dsp event pin level
	output logic dsp_debug_event_out, // dedicated dsp pin drive value
	output logic dsp_debug_event_oe_out, // dedicated dsp pin enable
	input wire logic alt_mcu_debug_event_in, // alternate mcu event pin
	output logic alt_mcu_debug_event_out, // alternate mcu drive value
	output logic alt_mcu_debug_event_oe_out, // alternate mcu enable
	input wire logic alt_dsp_debug_event_in, // alternate dsp event pin
	output logic alt_dsp_debug_event_out, // alternate dsp drive value
	output logic alt_dsp_debug_event_oe_out, // alternate dsp enable
	input wire logic mcu_break_in, // mcu breakpoint match pulse
	input wire logic dsp_break_in, // dsp breakpoint match pulse
	input wire logic mcu_debug_exit_in, // mcu leaves debug pulse
	input wire logic dsp_debug_exit_in, // dsp leaves debug pulse
	output logic mcu_debug_mode_out, // mcu in debug mode
	output logic dsp_debug_mode_out, // dsp in debug mode
	input wire logic tck_in, // dedicated test clock pin
	input wire logic tms_in, // dedicated mode select pin
	input wire logic tdi_in, // dedicated data in pin
	input wire logic trst_n_in, // dedicated test reset, active low
	output logic tdo_out, // dedicated tdo drive value
	output logic tdo_oe_out, // dedicated tdo enable
	input wire logic alt_keypad_row_seven_pin_in, // alternate test clock
	input wire logic alt_interrupt_seven_pin_in, // alternate mode select
	input wire logic uart_rx_in, // alternate data in
	input wire logic alt_interrupt_six_pin_in, // alternate test reset
	output logic uart_tx_out, // alternate tdo drive value
	output logic uart_tx_oe_out // alternate tdo enable
);
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [1:0] route_sync_ff;
	logic route_ff;
	logic [1:0] ev_sync_ff [2];
	logic [1:0] ev_prev_ff;
	logic [1:0] mode_ff;
	logic [1:0] ack_cnt_ff [2];
	logic [1:0] ack_ff;
	logic [1:0] ack_route_ff;
	logic [1:0] ev_pin;
	logic [1:0] brk;
	logic [1:0] ext;
	logic [1:0] req;
	dbg_pkg::dbg_jtag_in_t jt;
	dbg_pkg::dbg_tap_state_t tap_state;
	logic tap_tdo;
	logic tap_tdo_oe;

	// ---------------------------------------------------------------
	// reset release and route select synchronisers
	// ---------------------------------------------------------------
	// release through two flops so every core-clock flop leaves reset together; the tap flops use the test reset
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'h1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// route select is a pin; third stage feeds the event lines, the test port uses the raw pin
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			route_sync_ff <= 2'h0;
			route_ff <= 1'b0;
		end else begin
			route_sync_ff <= {route_sync_ff[0], pin_route_select_in};
			route_ff <= route_sync_ff[1];
		end
	end

	// ---------------------------------------------------------------
	// debug event lines, index 0 mcu and index 1 dsp
	// ---------------------------------------------------------------
	assign brk = {dsp_break_in, mcu_break_in};
	assign ext = {dsp_debug_exit_in, mcu_debug_exit_in};

	// pick the active pin pair before synchronising
	always_comb begin
		ev_pin[0] = route_ff ? alt_mcu_debug_event_in : mcu_debug_event_in;
		ev_pin[1] = route_ff ? alt_dsp_debug_event_in : dsp_debug_event_in;
	end

	for (genvar c = 0; c < 2; c++) begin : g_core
		// two flops before the falling-edge detector; idle line is high
		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n) begin
				ev_sync_ff[c] <= 2'h3;
				ev_prev_ff[c] <= 1'b1;
			end else begin
				ev_sync_ff[c] <= {ev_sync_ff[c][0], ev_pin[c]};
				ev_prev_ff[c] <= ev_sync_ff[c][1];
			end
		end

		// own acknowledge reads back low; ignore it as a request
		assign req[c] = (ev_prev_ff[c] && !ev_sync_ff[c][1] &&
			!ack_ff[c]) || brk[c];

		// debug mode: entry wins over a coincident exit
		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n) begin
				mode_ff[c] <= 1'b0;
			end else if (req[c] && !mode_ff[c]) begin
				mode_ff[c] <= 1'b1;
			end else if (ext[c]) begin
				mode_ff[c] <= 1'b0;
			end
		end

		// three-cycle acknowledge counter started on entry
		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n) begin
				ack_cnt_ff[c] <= dbg_pkg::ACK_CNT_RESET;
				ack_ff[c] <= 1'b0;
			end else if (req[c] && !mode_ff[c]) begin
				ack_cnt_ff[c] <= 2'(dbg_pkg::ACK_CYCLES - 1);
				ack_ff[c] <= 1'b1;
			end else if (ack_cnt_ff[c] != dbg_pkg::ACK_CNT_RESET) begin
				ack_cnt_ff[c] <= ack_cnt_ff[c] - 2'h1;
			end else begin
				ack_ff[c] <= 1'b0;
			end
		end

		// route of the acknowledge latched with it so a pulse never splits
		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n) begin
				ack_route_ff[c] <= 1'b0;
			end else if (req[c] && !mode_ff[c]) begin
				ack_route_ff[c] <= route_ff;
			end
		end
	end

	// open drain: value is always low, enable carries the pulse
	assign mcu_debug_event_out = 1'b0;
	assign dsp_debug_event_out = 1'b0;
	assign alt_mcu_debug_event_out = 1'b0;
	assign alt_dsp_debug_event_out = 1'b0;
	assign mcu_debug_event_oe_out = ack_ff[0] && !ack_route_ff[0];
	assign alt_mcu_debug_event_oe_out = ack_ff[0] && ack_route_ff[0];
	assign dsp_debug_event_oe_out = ack_ff[1] && !ack_route_ff[1];
	assign alt_dsp_debug_event_oe_out = ack_ff[1] && ack_route_ff[1];
	assign mcu_debug_mode_out = mode_ff[0];
	assign dsp_debug_mode_out = mode_ff[1];

	// ---------------------------------------------------------------
	// test port routing
	// ---------------------------------------------------------------
	// raw pin select: the route pin is a static strap, changing it
	// while the tap runs may glitch the test clock
	always_comb begin
		jt.tck = pin_route_select_in ? alt_keypad_row_seven_pin_in : tck_in;
		jt.tms = pin_route_select_in ? alt_interrupt_seven_pin_in : tms_in;
		jt.tdi = pin_route_select_in ? uart_rx_in : tdi_in;
		jt.trst_n = pin_route_select_in ? alt_interrupt_six_pin_in : trst_n_in;
	end

	dbg_tap u_tap (
		.tck_in(jt.tck),
		.trst_n_in(jt.trst_n),
		.tms_in(jt.tms),
		.tdi_in(jt.tdi),
		.tdo_out(tap_tdo),
		.tdo_oe_out(tap_tdo_oe),
		.state_out(tap_state)
	);

	// tdo leaves on the selected pin only; the other stays undriven
	assign tdo_out = tap_tdo;
	assign uart_tx_out = tap_tdo;
	assign tdo_oe_out = tap_tdo_oe && !pin_route_select_in;
	assign uart_tx_oe_out = tap_tdo_oe && pin_route_select_in;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_mcu_ack_three;
		@(posedge clk_in) disable iff (!rst_n)
		$rose(ack_ff[0]) |-> ack_ff[0] [*3] ##1 !ack_ff[0];
	endproperty
	a_mcu_ack_three: assert property (p_mcu_ack_three)
		else $error("mcu acknowledge not three cycles");

	property p_dsp_ack_three;
		@(posedge clk_in) disable iff (!rst_n)
		$rose(ack_ff[1]) |-> ack_ff[1] [*3] ##1 !ack_ff[1];
	endproperty
	a_dsp_ack_three: assert property (p_dsp_ack_three)
		else $error("dsp acknowledge not three cycles");

	property p_mcu_entry_acks;
		@(posedge clk_in) disable iff (!rst_n)
		$rose(mode_ff[0]) |-> $rose(ack_ff[0]);
	endproperty
	a_mcu_entry_acks: assert property (p_mcu_entry_acks)
		else $error("mcu debug entry without acknowledge");

	property p_ext_request;
		@(posedge clk_in) disable iff (!rst_n)
		(ev_prev_ff[1] && !ev_sync_ff[1][1] && !ack_ff[1]) |=> mode_ff[1];
	endproperty
	a_ext_request: assert property (p_ext_request)
		else $error("dsp request did not enter debug mode");

	property p_alt_route_event;
		@(posedge clk_in) disable iff (!rst_n)
		(ack_ff[0] && ack_route_ff[0]) |-> !mcu_debug_event_oe_out;
	endproperty
	a_alt_route_event: assert property (p_alt_route_event)
		else $error("dedicated mcu pin driven on alternate route");

	property p_alt_tdo;
		@(posedge clk_in) disable iff (!rst_n)
		pin_route_select_in |-> !tdo_oe_out;
	endproperty
	a_alt_tdo: assert property (p_alt_tdo)
		else $error("dedicated tdo driven on alternate route");
endmodule // dbg_port

/* File: bench/dbg_far_model.sv */
// far-side model: debug command converter and test controller
`timescale 1ns/10ps
module dbg_far_model (
	input wire logic mcu_oe_in, // device pulls mcu line low
	input wire logic dsp_oe_in, // device pulls dsp line low
	input wire logic tdo_in, // selected tdo value
	input wire logic tdo_oe_in, // selected tdo enable
	output logic mcu_line_out, // mcu line with pull-up
	output logic dsp_line_out, // dsp line with pull-up
	output logic tck_out, // test clock, still between frames
	output logic tms_out, // mode select
	output logic tdi_out, // serial data in
	output logic trst_n_out // test reset, active low
);
	logic [1:0] pull;
	// ---------------------------------------------------------------
	// open-drain event lines
	// ---------------------------------------------------------------
	// pull-up wins unless either party pulls the line low
	assign mcu_line_out = ~(mcu_oe_in | pull[0]);
	assign dsp_line_out = ~(dsp_oe_in | pull[1]);
	// idle levels at time zero
	initial begin
		pull = 2'h0;
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b1;
		trst_n_out = 1'b1;
	end
	// request is two core clocks low, long enough for the synchroniser
	task automatic request(input logic dsp);
		pull[dsp] = 1'b1;
		#100;
		pull[dsp] = 1'b0;
	endtask
	// one 125 ns test clock; tms and tdi settle in the low phase and
	// are held over the rising edge, where tdo is taken as well
	task automatic tck_cycle(input logic tms, input logic tdi,
		output logic tdo, output logic oe);
		tms_out = tms;
		tdi_out = tdi;
		#31.25;
		tdo = tdo_in;
		oe = tdo_oe_in;
		tck_out = 1'b1;
		#62.5;
		tck_out = 1'b0;
		tdi_out = ~tdi; // stale data is not left on the line
		#31.25;
	endtask
	// asynchronous test reset with the test clock standing still
	task automatic tap_reset();
		trst_n_out = 1'b0;
		#100;
		trst_n_out = 1'b1;
		#100;
	endtask
endmodule // dbg_far_model

/* File: bench/dbg_port_tb_top.sv */
// self-checking bench for the debug event and test port
`timescale 1ns/10ps
module dbg_port_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, route = 1'b0;
	logic [1:0] brk = 2'h0, ext = 2'h0;
	logic mcu_oe, dsp_oe, amcu_oe, adsp_oe, mcu_mode, dsp_mode;
	logic tdo, tdo_oe, utx, utx_oe, p_mcu, p_dsp, tck, tms, tdi, trst_n;
	logic [3:0] ev_val;
	int fail_count = 0, compares = 0;
	wire logic [1:0] oe_sel = route ? {adsp_oe, amcu_oe} : {dsp_oe, mcu_oe};
	wire logic [1:0] oe_off = route ? {dsp_oe, mcu_oe} : {adsp_oe, amcu_oe};
	wire logic [1:0] mode = {dsp_mode, mcu_mode};
	// ---------------------------------------------------------------
	// clock, design and far side
	// ---------------------------------------------------------------
	always #25 clk = ~clk;
	// unselected pins carry idle, inverted or reset levels so misrouting shows; both tck pins get the clock
	dbg_port uut (
		.clk_in(clk), .reset_n_in(rst_n), .pin_route_select_in(route),
		.mcu_debug_event_in(route ? 1'b1 : p_mcu),
		.mcu_debug_event_out(ev_val[0]), .mcu_debug_event_oe_out(mcu_oe),
		.dsp_debug_event_in(route ? 1'b1 : p_dsp),
		.dsp_debug_event_out(ev_val[1]), .dsp_debug_event_oe_out(dsp_oe),
		.alt_mcu_debug_event_in(route ? p_mcu : 1'b1),
		.alt_mcu_debug_event_out(ev_val[2]),
		.alt_mcu_debug_event_oe_out(amcu_oe),
		.alt_dsp_debug_event_in(route ? p_dsp : 1'b1),
		.alt_dsp_debug_event_out(ev_val[3]),
		.alt_dsp_debug_event_oe_out(adsp_oe),
		.mcu_break_in(brk[0]), .dsp_break_in(brk[1]),
		.mcu_debug_exit_in(ext[0]), .dsp_debug_exit_in(ext[1]),
		.mcu_debug_mode_out(mcu_mode), .dsp_debug_mode_out(dsp_mode),
		.tck_in(tck), .tms_in(route ? ~tms : tms),
		.tdi_in(route ? ~tdi : tdi), .trst_n_in(route ? 1'b0 : trst_n),
		.tdo_out(tdo), .tdo_oe_out(tdo_oe),
		.alt_keypad_row_seven_pin_in(tck),
		.alt_interrupt_seven_pin_in(route ? tms : ~tms),
		.uart_rx_in(route ? tdi : ~tdi),
		.alt_interrupt_six_pin_in(route ? trst_n : 1'b0),
		.uart_tx_out(utx), .uart_tx_oe_out(utx_oe)
	);
	dbg_far_model far (
		.mcu_oe_in(oe_sel[0]), .dsp_oe_in(oe_sel[1]),
		.tdo_in(route ? utx : tdo), .tdo_oe_in(route ? utx_oe : tdo_oe),
		.mcu_line_out(p_mcu), .dsp_line_out(p_dsp), .tck_out(tck),
		.tms_out(tms), .tdi_out(tdi), .trst_n_out(trst_n)
	);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %0h exp %0h", $time,
				what, got, exp);
		end
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	// entry by pin or breakpoint, ack length, refusal in debug, exit
	task automatic ev_test(input logic dsp, input logic pin);
		int n;
		int cnt;
		n = 0;
		cnt = 0;
		step();
		if (pin) begin
			far.request(dsp);
		end else begin
			brk[dsp] = 1'b1;
			step();
			brk[dsp] = 1'b0;
		end
		while (oe_sel[dsp] !== 1'b1 && n < 6) begin
			step();
			n++;
		end
		chk(8'(n <= (pin ? 3 : 0)), 8'h01, "ack latency");
		chk({7'h0, mode[dsp]}, 8'h01, "mode entered");
		while (oe_sel[dsp] === 1'b1 && cnt < 9) begin
			chk({6'h0, oe_off}, 8'h00, "unselected pins");
			chk({7'h0, oe_sel[~dsp]}, 8'h00, "other core ack");
			chk({4'h0, ev_val}, 8'h00, "drive value low");
			step();
			cnt++;
		end
		chk(8'(cnt), 8'(dbg_pkg::ACK_CYCLES), "ack length");
		// a second breakpoint while in debug must not ack again
		brk[dsp] = 1'b1;
		step();
		brk[dsp] = 1'b0;
		repeat (3) begin
			chk({7'h0, oe_sel[dsp]}, 8'h00, "refused entry");
			step();
		end
		ext[dsp] = 1'b1;
		step();
		ext[dsp] = 1'b0;
		chk({7'h0, mode[dsp]}, 8'h00, "mode left");
	endtask
	// ir shift shows capture 0001 lsb first, then bypass delays tdi
	task automatic jtag_test();
		logic [20:0] tms_v = 21'h038706;
		logic [20:0] tdi_v = 21'h00A000;
		logic [20:0] oe_v = 21'h10E1E0;
		logic [20:0] tdo_v = 21'h004020;
		logic got_tdo;
		logic got_oe;
		far.tap_reset();
		for (int i = 0; i < 21; i++) begin
			far.tck_cycle(tms_v[i], tdi_v[i], got_tdo, got_oe);
			chk({7'h0, got_oe}, {7'h0, oe_v[i]}, "tdo enable");
			if (oe_v[i])
				chk({7'h0, got_tdo}, {7'h0, tdo_v[i]}, "tdo bit");
			chk({7'h0, route ? tdo_oe : utx_oe}, 8'h00, "unused tdo");
		end
		// still in shift-dr: reset must float tdo with no test clock
		far.tap_reset();
		chk({7'h0, route ? utx_oe : tdo_oe}, 8'h00, "tdo after reset");
	endtask
	// ---------------------------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		repeat (4) step();
		for (int r = 0; r < 2; r++) begin
			route = r[0];
			jtag_test();
			for (int k = 0; k < 4; k++)
				ev_test(k[0], k[1]);
		end
		conclude();
	end
	// the run needs about 11 us; nine times that means a hang
	initial begin
		#100000;
		fail_count++;
		conclude();
	end
endmodule // dbg_port_tb_top
